// >>> slave_comm_pkg.sv
// constants and types for the slave communication state machine
// Behaviour
// - after reset state is init; mailbox and process data refused there.
// - init to preop accepted only if mailbox configuration is valid.
// - preop serves mailbox, rejects process data.
// - preop to safeop checks process data channels and time base if needed.
// - inputs copied into shared memory before safeop is acknowledged; the code raises mem_in_write in the same cycle as ack_valid.
// - safeop serves mailbox and process data, inputs cyclic, outputs safe.
// - watchdog on forces safe value; watchdog off lets safeop drive outputs.
// - operational copies master output data to outputs; all traffic served.
// - bootstrap entered only from init.
// - bootstrap allows only file transfer mailbox; all else refused.
// - application object mailbox unsupported in every state.
// - 64-bit nanosecond local time counter, zero at 2000-01-01 00:00.
// - reduced build may keep only a wrapping 32-bit time counter.
package slave_comm_pkg;
  typedef enum logic [2:0] {
    st_init_t_val, st_preop, st_safeop, st_op, st_boot
  } comm_state_t;
  // state request codes from the master
  localparam logic [2:0] REQ_INIT   = 3'h1;
  localparam logic [2:0] REQ_PREOP  = 3'h2;
  localparam logic [2:0] REQ_BOOT   = 3'h3;
  localparam logic [2:0] REQ_SAFEOP = 3'h4;
  localparam logic [2:0] REQ_OP     = 3'h5;
  // reported state codes
  localparam logic [3:0] CODE_INIT   = 4'h1;
  localparam logic [3:0] CODE_PREOP  = 4'h2;
  localparam logic [3:0] CODE_BOOT   = 4'h3;
  localparam logic [3:0] CODE_SAFEOP = 4'h4;
  localparam logic [3:0] CODE_OP     = 4'h8;
  // mailbox protocol codes
  localparam logic [3:0] MBX_APP_OBJ = 4'h3;
  localparam logic [3:0] MBX_FILE    = 4'h4;
  // error codes
  localparam logic [3:0] ERR_NONE      = 4'h0;
  localparam logic [3:0] ERR_BAD_TRANS = 4'h1;
  localparam logic [3:0] ERR_MBX_CFG   = 4'h2;
  localparam logic [3:0] ERR_PD_CFG    = 4'h3;
  localparam logic [3:0] ERR_TIME_CFG  = 4'h4;
  // time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIME_RES_NS   = 1;
  localparam logic [7:0] TIME_STEP = 8'(CLK_PERIOD_NS / TIME_RES_NS);
  localparam int TIME_WIDTH    = 64;
  localparam int DATA_WIDTH    = 16;
  localparam int FIFO_DEPTH    = 8;
endpackage : slave_comm_pkg

// >>> pd_fifo.sv
// parameterised valid/ready fifo for process data words
`timescale 1ns/1ns
`default_nettype none
module pd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  // full and empty straight from the count
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset; only pointers and count need one
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge core_clk) begin
    if (!resetn || flush) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - (AW+1)'(1);
      end
    end
  end
endmodule : pd_fifo
`default_nettype wire

// >>> slave_comm_state_machine.sv
// slave communication state machine with gated data paths and local time base
`timescale 1ns/1ns
`default_nettype none
module slave_comm_state_machine #(
  parameter int  DATA_WIDTH   = slave_comm_pkg::DATA_WIDTH,
  parameter int  FIFO_DEPTH   = slave_comm_pkg::FIFO_DEPTH,
  parameter int  TIME_WIDTH   = slave_comm_pkg::TIME_WIDTH,
  parameter bit  TIME_REDUCED = 1'b0
) (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  // state requests from the master
  input  wire logic                  req_valid,
  input  wire logic [2:0]            req_state,
  input  wire logic                  mbx_cfg_ok,
  input  wire logic                  pd_cfg_ok,
  input  wire logic                  time_cfg_needed,
  input  wire logic                  time_cfg_ok,
  input  wire logic                  watchdog_enable,
  input  wire logic                  err_ack,
  output logic                       ack_valid,
  output logic [3:0]                 state_code,
  output logic                       err_flag,
  output logic [3:0]                 err_code,
  // mailbox requests
  input  wire logic                  mbx_valid,
  input  wire logic [3:0]            mbx_proto,
  output logic                       mbx_accept,
  output logic                       mbx_refuse,
  output logic                       mbx_unsupported,
  // process data from master to outputs
  input  wire logic [DATA_WIDTH-1:0] pd_out_data,
  input  wire logic                  pd_out_valid,
  output logic                       pd_out_ready,
  output logic                       pd_refuse,
  input  wire logic                  phys_ready,
  output logic [DATA_WIDTH-1:0]      phys_out,
  input  wire logic [DATA_WIDTH-1:0] safe_value,
  // inputs toward shared memory
  input  wire logic [DATA_WIDTH-1:0] phys_in,
  output logic [DATA_WIDTH-1:0]      mem_in_data,
  output logic                       mem_in_write,
  // local time base
  input  wire logic                  time_load,
  input  wire logic [TIME_WIDTH-1:0] time_load_value,
  output logic [TIME_WIDTH-1:0]      local_time
);
  slave_comm_pkg::comm_state_t state_reg;
  logic                  copy_pending_reg;
  logic [DATA_WIDTH-1:0] in_s1_reg;
  logic [DATA_WIDTH-1:0] in_s2_reg;
  logic                  pd_allowed;
  logic                  drive_allowed;
  logic                  fifo_out_valid;
  logic [DATA_WIDTH-1:0] fifo_out_data;
  logic                  fifo_in_ready;
  logic                  fifo_pop;
  logic                  fifo_push;
  logic                  trans_ok;
  logic                  trans_legal;
  logic [3:0]            trans_err;

  // process data only in safeop and op
  assign pd_allowed    = (state_reg == slave_comm_pkg::st_safeop) ||
                         (state_reg == slave_comm_pkg::st_op);
  // outputs follow data in op, or in safeop when watchdog is off
  assign drive_allowed = (state_reg == slave_comm_pkg::st_op) ||
                         ((state_reg == slave_comm_pkg::st_safeop) && !watchdog_enable);
  // pop when the sink takes a word
  assign fifo_pop      = fifo_out_valid && drive_allowed && phys_ready;
  assign fifo_push     = pd_out_valid && pd_out_ready;

  // registered ready, low for a cycle after a push or a request,
  // so a full fifo is never overrun and no word crosses a state change
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pd_out_ready <= 1'b0;
    end else begin
      pd_out_ready <= pd_allowed && fifo_in_ready && !fifo_push && !req_valid;
    end
  end

  // fifo flushes outside pd states so stale data never reaches outputs
  pd_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .flush     (!pd_allowed),
    .in_data   (pd_out_data),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (drive_allowed && phys_ready)
  );

  // transition legality and configuration checks
  always_comb begin
    trans_legal = 1'b0;
    trans_ok    = 1'b0;
    trans_err   = slave_comm_pkg::ERR_BAD_TRANS;
    case (req_state)
      slave_comm_pkg::REQ_INIT: begin
        trans_legal = 1'b1;
        trans_ok    = 1'b1;
      end
      slave_comm_pkg::REQ_PREOP: begin
        trans_legal = (state_reg == slave_comm_pkg::st_init_t_val) ||
                      (state_reg == slave_comm_pkg::st_preop) ||
                      (state_reg == slave_comm_pkg::st_safeop) ||
                      (state_reg == slave_comm_pkg::st_op);
        if (state_reg == slave_comm_pkg::st_init_t_val) begin
          trans_ok  = trans_legal && mbx_cfg_ok;
          trans_err = mbx_cfg_ok ? slave_comm_pkg::ERR_NONE : slave_comm_pkg::ERR_MBX_CFG;
        end else begin
          trans_ok = trans_legal;
        end
      end
      slave_comm_pkg::REQ_BOOT: begin
        trans_legal = (state_reg == slave_comm_pkg::st_init_t_val) ||
                      (state_reg == slave_comm_pkg::st_boot);
        trans_ok    = trans_legal;
      end
      slave_comm_pkg::REQ_SAFEOP: begin
        trans_legal = (state_reg == slave_comm_pkg::st_preop) ||
                      (state_reg == slave_comm_pkg::st_safeop) ||
                      (state_reg == slave_comm_pkg::st_op);
        if (state_reg == slave_comm_pkg::st_preop) begin
          if (!pd_cfg_ok) begin
            trans_err = slave_comm_pkg::ERR_PD_CFG;
          end else if (time_cfg_needed && !time_cfg_ok) begin
            trans_err = slave_comm_pkg::ERR_TIME_CFG;
          end else begin
            trans_ok = 1'b1;
          end
        end else begin
          trans_ok = trans_legal;
        end
      end
      slave_comm_pkg::REQ_OP: begin
        trans_legal = (state_reg == slave_comm_pkg::st_safeop) ||
                      (state_reg == slave_comm_pkg::st_op);
        trans_ok    = trans_legal;
      end
      default: begin
        trans_legal = 1'b0;
      end
    endcase
  end

  // state register; safeop entry from preop waits one cycle for the input copy
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg        <= slave_comm_pkg::st_init_t_val;
      copy_pending_reg <= 1'b0;
      ack_valid        <= 1'b0;
    end else begin
      ack_valid <= 1'b0;
      if (copy_pending_reg) begin
        copy_pending_reg <= 1'b0;
        state_reg        <= slave_comm_pkg::st_safeop;
        ack_valid        <= 1'b1;
      end else if (req_valid && trans_ok) begin
        case (req_state)
          slave_comm_pkg::REQ_INIT:   state_reg <= slave_comm_pkg::st_init_t_val;
          slave_comm_pkg::REQ_PREOP:  state_reg <= slave_comm_pkg::st_preop;
          slave_comm_pkg::REQ_BOOT:   state_reg <= slave_comm_pkg::st_boot;
          // from preop the copy cycle moves the state
          slave_comm_pkg::REQ_SAFEOP: begin
            if (state_reg != slave_comm_pkg::st_preop) begin
              state_reg <= slave_comm_pkg::st_safeop;
            end
          end
          slave_comm_pkg::REQ_OP:     state_reg <= slave_comm_pkg::st_op;
          default:                    state_reg <= state_reg;
        endcase
        if (req_state == slave_comm_pkg::REQ_SAFEOP &&
            state_reg == slave_comm_pkg::st_preop) begin
          copy_pending_reg <= 1'b1;
        end else begin
          ack_valid <= 1'b1;
        end
      end
    end
  end

  // sticky error; a new failure beats a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      err_flag <= 1'b0;
      err_code <= slave_comm_pkg::ERR_NONE;
    end else if (req_valid && !copy_pending_reg && !trans_ok) begin
      err_flag <= 1'b1;
      err_code <= trans_legal ? trans_err : slave_comm_pkg::ERR_BAD_TRANS;
    end else if (err_ack) begin
      err_flag <= 1'b0;
      err_code <= slave_comm_pkg::ERR_NONE;
    end
  end

  // status code of present state
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_code <= slave_comm_pkg::CODE_INIT;
    end else begin
      case (state_reg)
        slave_comm_pkg::st_preop:  state_code <= slave_comm_pkg::CODE_PREOP;
        slave_comm_pkg::st_safeop: state_code <= slave_comm_pkg::CODE_SAFEOP;
        slave_comm_pkg::st_op:     state_code <= slave_comm_pkg::CODE_OP;
        slave_comm_pkg::st_boot:   state_code <= slave_comm_pkg::CODE_BOOT;
        default:                   state_code <= slave_comm_pkg::CODE_INIT;
      endcase
    end
  end

  // mailbox gating; one-cycle answer per request
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mbx_accept      <= 1'b0;
      mbx_refuse      <= 1'b0;
      mbx_unsupported <= 1'b0;
    end else begin
      mbx_accept      <= 1'b0;
      mbx_refuse      <= 1'b0;
      mbx_unsupported <= 1'b0;
      if (mbx_valid) begin
        if (mbx_proto == slave_comm_pkg::MBX_APP_OBJ) begin
          mbx_unsupported <= 1'b1;
        end else if (state_reg == slave_comm_pkg::st_init_t_val) begin
          mbx_refuse <= 1'b1;
        end else if (state_reg == slave_comm_pkg::st_boot) begin
          mbx_accept <= (mbx_proto == slave_comm_pkg::MBX_FILE);
          mbx_refuse <= (mbx_proto != slave_comm_pkg::MBX_FILE);
        end else begin
          mbx_accept <= 1'b1;
        end
      end
    end
  end

  // process data refusal flag for offered words outside pd states
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pd_refuse <= 1'b0;
    end else begin
      pd_refuse <= pd_out_valid && !pd_allowed;
    end
  end

  // physical outputs: data in op or in safeop with watchdog off, safe value otherwise
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phys_out <= '0;
    end else if (fifo_pop) begin
      phys_out <= fifo_out_data;
    end else if (!drive_allowed) begin
      phys_out <= safe_value;
    end
  end

  // inputs come from pins, so two stages before use
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      in_s1_reg <= '0;
      in_s2_reg <= '0;
    end else begin
      in_s1_reg <= phys_in;
      in_s2_reg <= in_s1_reg;
    end
  end

  // input copy on safeop entry and cyclically while pd runs
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mem_in_data  <= '0;
      mem_in_write <= 1'b0;
    end else begin
      mem_in_write <= copy_pending_reg || pd_allowed;
      mem_in_data  <= in_s2_reg;
    end
  end

  // local time in ns; reduced build wraps at 32 bits, master may reload
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      local_time <= '0;
    end else if (time_load && TIME_REDUCED) begin
      local_time <= {{(TIME_WIDTH-32){1'b0}}, time_load_value[31:0]};
    end else if (time_load) begin
      local_time <= time_load_value;
    end else if (TIME_REDUCED) begin
      local_time <= {{(TIME_WIDTH-32){1'b0}},
                     local_time[31:0] + 32'(slave_comm_pkg::TIME_STEP)};
    end else begin
      local_time <= local_time + TIME_WIDTH'(slave_comm_pkg::TIME_STEP);
    end
  end
endmodule : slave_comm_state_machine
`default_nettype wire

// >>> slave_comm_sm_properties.sv
// port-level assertions for the slave communication state machine
`timescale 1ns/1ns
`default_nettype none
module slave_comm_sm_properties #(
  parameter int TIME_WIDTH = 64
) (
  input wire logic                  core_clk,
  input wire logic                  resetn,
  input wire logic                  req_valid,
  input wire logic [2:0]            req_state,
  input wire logic                  mbx_cfg_ok,
  input wire logic                  ack_valid,
  input wire logic [3:0]            state_code,
  input wire logic                  err_flag,
  input wire logic [3:0]            err_code,
  input wire logic                  mbx_valid,
  input wire logic [3:0]            mbx_proto,
  input wire logic                  mbx_accept,
  input wire logic                  mbx_refuse,
  input wire logic                  mbx_unsupported,
  input wire logic                  pd_out_valid,
  input wire logic                  pd_out_ready,
  input wire logic                  pd_refuse,
  input wire logic                  time_load,
  input wire logic [TIME_WIDTH-1:0] time_load_value,
  input wire logic [TIME_WIDTH-1:0] local_time
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // state_code lags the state by a cycle, so guards skip the cycle of an acknowledge
  property p_reset_idle;
    $rose(resetn) |-> state_code == slave_comm_pkg::CODE_INIT && local_time == '0 && !ack_valid && !err_flag;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("block not idle in init after reset");
  property p_app_unsup;
    mbx_valid && mbx_proto == slave_comm_pkg::MBX_APP_OBJ |=> mbx_unsupported && !mbx_accept && !mbx_refuse;
  endproperty
  a_app_unsup: assert property (p_app_unsup) else $error("app object mailbox not unsupported");
  property p_init_refuse;
    mbx_valid && mbx_proto != slave_comm_pkg::MBX_APP_OBJ && state_code == slave_comm_pkg::CODE_INIT && !ack_valid
      |=> mbx_refuse && !mbx_accept;
  endproperty
  a_init_refuse: assert property (p_init_refuse) else $error("mailbox served in init");
  property p_boot_file;
    mbx_valid && state_code == slave_comm_pkg::CODE_BOOT && !ack_valid
      |=> mbx_accept == ($past(mbx_proto) == slave_comm_pkg::MBX_FILE);
  endproperty
  a_boot_file: assert property (p_boot_file) else $error("wrong mailbox answer in bootstrap");
  property p_pd_gate;
    pd_out_valid && !ack_valid && (state_code == slave_comm_pkg::CODE_INIT || state_code == slave_comm_pkg::CODE_PREOP)
      |-> !pd_out_ready ##1 pd_refuse;
  endproperty
  a_pd_gate: assert property (p_pd_gate) else $error("process data not refused");
  property p_mbx_cfg;
    req_valid && req_state == slave_comm_pkg::REQ_PREOP && state_code == slave_comm_pkg::CODE_INIT && !ack_valid
      && !$past(req_valid) && !mbx_cfg_ok
      |=> err_flag && err_code == slave_comm_pkg::ERR_MBX_CFG && !ack_valid ##1 state_code == slave_comm_pkg::CODE_INIT;
  endproperty
  a_mbx_cfg: assert property (p_mbx_cfg) else $error("bad mailbox setup accepted");
  property p_boot_entry;
    req_valid && req_state == slave_comm_pkg::REQ_BOOT && !ack_valid && !$past(req_valid)
      && state_code != slave_comm_pkg::CODE_INIT && state_code != slave_comm_pkg::CODE_BOOT
      |=> err_flag && err_code == slave_comm_pkg::ERR_BAD_TRANS ##1 $stable(state_code);
  endproperty
  a_boot_entry: assert property (p_boot_entry) else $error("bootstrap entered from wrong state");
  property p_time_base;
    resetn |=> local_time == ($past(time_load) ? $past(time_load_value)
      : $past(local_time) + TIME_WIDTH'(slave_comm_pkg::TIME_STEP));
  endproperty
  a_time_base: assert property (p_time_base) else $error("local time step or load wrong");
endmodule : slave_comm_sm_properties
bind slave_comm_state_machine slave_comm_sm_properties #(.TIME_WIDTH(TIME_WIDTH)) u_props (
  .core_clk, .resetn, .req_valid, .req_state, .mbx_cfg_ok, .ack_valid, .state_code, .err_flag, .err_code,
  .mbx_valid, .mbx_proto, .mbx_accept, .mbx_refuse, .mbx_unsupported, .pd_out_valid, .pd_out_ready,
  .pd_refuse, .time_load, .time_load_value, .local_time
);
`default_nettype wire

// >>> master_model.sv
// bus master model: state requests, process data words and time loads
`timescale 1ns/1ns
`default_nettype none
module master_model #(
  parameter int DW = 16,
  parameter int TW = 64
) (
  input  wire logic          core_clk,
  input  wire logic          ack_valid,
  input  wire logic          pd_out_ready,
  output logic               req_valid,
  output logic [2:0]         req_state,
  output logic               mbx_cfg_ok,
  output logic               pd_cfg_ok,
  output logic               time_cfg_needed,
  output logic               time_cfg_ok,
  output logic [DW-1:0]      pd_out_data,
  output logic               pd_out_valid,
  output logic               time_load,
  output logic [TW-1:0]      time_load_value
);
  // idle levels; this master always asks for the time base check
  initial begin
    {req_valid, req_state, mbx_cfg_ok, pd_cfg_ok, time_cfg_ok} = '0;
    time_cfg_needed = 1'b1;
    {pd_out_data, pd_out_valid, time_load, time_load_value} = '0;
  end
  // one request; cfg is {time, process data, mailbox} setup correct
  task automatic request(input logic [2:0] code, input logic [2:0] cfg, output bit got);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_state <= code;
    {time_cfg_ok, pd_cfg_ok, mbx_cfg_ok} <= cfg;
    @(posedge core_clk);
    req_valid <= 1'b0;
    got = 1'b0;
    for (int i = 0; i < 3 && !got; i++) begin
      #1 got = (ack_valid === 1'b1);
      if (!got) @(posedge core_clk);
    end
  endtask : request
  // offer a word until taken; gives up after a few edges so refusals return
  task automatic send_word(input logic [DW-1:0] d, output bit taken);
    @(posedge core_clk);
    pd_out_valid <= 1'b1;
    pd_out_data  <= d;
    taken = 1'b0;
    for (int i = 0; i < 4 && !taken; i++) begin
      @(posedge core_clk);
      taken = (pd_out_ready === 1'b1);
    end
    pd_out_valid <= 1'b0;
    pd_out_data  <= ~d; // released bus must not keep the word
  endtask : send_word
  // resynchronise the local time
  task automatic load_time(input logic [TW-1:0] v);
    @(posedge core_clk);
    time_load       <= 1'b1;
    time_load_value <= v;
    @(posedge core_clk);
    time_load       <= 1'b0;
    time_load_value <= ~v;
  endtask : load_time
endmodule : master_model
`default_nettype wire

// >>> tb.sv
// self-checking bench for the slave communication state machine
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int DW = slave_comm_pkg::DATA_WIDTH;
  logic          core_clk = 1'b0, resetn = 1'b0, err_ack = 1'b0, mbx_valid = 1'b0;
  logic          phys_ready = 1'b0, watchdog_enable = 1'b1;
  logic [3:0]    mbx_proto = 4'h0, cur = slave_comm_pkg::CODE_INIT;
  logic [DW-1:0] safe_value, phys_in, pd_out_data, phys_out, mem_in_data;
  logic [DW-1:0] words [8];
  logic [2:0]    req_state;
  logic [3:0]    state_code, err_code;
  logic [63:0]   time_load_value, local_time, tv;
  logic          req_valid, mbx_cfg_ok, pd_cfg_ok, time_cfg_needed, time_cfg_ok, ack_valid, err_flag;
  logic          mbx_accept, mbx_refuse, mbx_unsupported, pd_out_valid, pd_out_ready, pd_refuse;
  logic          mem_in_write, time_load;
  integer        seed = 32'h2927;
  int            num_errors = 0, total_checks = 0, idx;
  bit            got;
  slave_comm_state_machine uut (
    .core_clk, .resetn, .req_valid, .req_state, .mbx_cfg_ok, .pd_cfg_ok, .time_cfg_needed, .time_cfg_ok,
    .watchdog_enable, .err_ack, .ack_valid, .state_code, .err_flag, .err_code, .mbx_valid, .mbx_proto,
    .mbx_accept, .mbx_refuse, .mbx_unsupported, .pd_out_data, .pd_out_valid, .pd_out_ready, .pd_refuse,
    .phys_ready, .phys_out, .safe_value, .phys_in, .mem_in_data, .mem_in_write, .time_load, .time_load_value,
    .local_time);
  master_model #(.DW(DW), .TW(64)) m (
    .core_clk, .ack_valid, .pd_out_ready, .req_valid, .req_state, .mbx_cfg_ok, .pd_cfg_ok, .time_cfg_needed,
    .time_cfg_ok, .pd_out_data, .pd_out_valid, .time_load, .time_load_value);
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  task automatic check(input bit ok, input string what);
    total_checks++;
    if (!ok) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // expected {unsupported, refuse, accept} for a mailbox request
  function automatic logic [2:0] exp_mbx(input logic [3:0] st, input logic [3:0] p);
    if (p == slave_comm_pkg::MBX_APP_OBJ) return 3'h4;
    if (st == slave_comm_pkg::CODE_INIT) return 3'h2;
    if (st == slave_comm_pkg::CODE_BOOT && p != slave_comm_pkg::MBX_FILE) return 3'h2;
    return 3'h1;
  endfunction : exp_mbx
  task automatic mbx(input logic [3:0] p);
    @(posedge core_clk);
    mbx_valid <= 1'b1;
    mbx_proto <= p;
    @(posedge core_clk);
    mbx_valid <= 1'b0;
    #1 check({mbx_unsupported, mbx_refuse, mbx_accept} === exp_mbx(cur, p), "mailbox answer");
  endtask : mbx
  task automatic mbx_sweep();
    mbx(slave_comm_pkg::MBX_APP_OBJ);
    mbx(slave_comm_pkg::MBX_FILE);
    mbx(4'($random(seed)));
  endtask : mbx_sweep
  // request a state; a failure is cleared again so later steps start clean
  task automatic go(input logic [2:0] code, input logic [2:0] cfg, input logic [3:0] st, input logic [3:0] err);
    m.request(code, cfg, got);
    check(got === (err == slave_comm_pkg::ERR_NONE), "acknowledge");
    @(posedge core_clk);
    #1 check(state_code === st, "reported state");
    check(err_code === err, "error code");
    cur = st;
    if (err != slave_comm_pkg::ERR_NONE) begin
      @(posedge core_clk);
      err_ack <= 1'b1;
      @(posedge core_clk);
      err_ack <= 1'b0;
      #1 check(err_flag === 1'b0, "error not cleared");
    end
  endtask : go
  // hang guard, well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    safe_value = 16'($random(seed));
    phys_in = 16'($random(seed));
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    #1 check(state_code === slave_comm_pkg::CODE_INIT && local_time === '0 && phys_out === '0, "reset");
    mbx_sweep();
    m.send_word(16'($random(seed)), got);
    check(got === 1'b0, "word taken in init");
    go(slave_comm_pkg::REQ_BOOT, 3'h7, slave_comm_pkg::CODE_BOOT, slave_comm_pkg::ERR_NONE);
    mbx_sweep();
    m.send_word(16'($random(seed)), got);
    check(got === 1'b0, "word taken in bootstrap");
    go(slave_comm_pkg::REQ_INIT, 3'h7, slave_comm_pkg::CODE_INIT, slave_comm_pkg::ERR_NONE);
    go(slave_comm_pkg::REQ_PREOP, 3'h6, slave_comm_pkg::CODE_INIT, slave_comm_pkg::ERR_MBX_CFG);
    go(slave_comm_pkg::REQ_PREOP, 3'h7, slave_comm_pkg::CODE_PREOP, slave_comm_pkg::ERR_NONE);
    mbx_sweep();
    m.send_word(16'($random(seed)), got);
    check(got === 1'b0, "word taken in preop");
    go(slave_comm_pkg::REQ_BOOT, 3'h7, slave_comm_pkg::CODE_PREOP, slave_comm_pkg::ERR_BAD_TRANS);
    go(slave_comm_pkg::REQ_SAFEOP, 3'h5, slave_comm_pkg::CODE_PREOP, slave_comm_pkg::ERR_PD_CFG);
    go(slave_comm_pkg::REQ_SAFEOP, 3'h3, slave_comm_pkg::CODE_PREOP, slave_comm_pkg::ERR_TIME_CFG);
    go(slave_comm_pkg::REQ_SAFEOP, 3'h7, slave_comm_pkg::CODE_SAFEOP, slave_comm_pkg::ERR_NONE);
    check(mem_in_write === 1'b1 && mem_in_data === phys_in, "inputs not copied");
    @(posedge core_clk);
    phys_in <= 16'($random(seed));
    repeat (4) @(posedge core_clk);
    #1 check(mem_in_data === phys_in, "inputs not cyclic");
    mbx_sweep();
    for (int i = 0; i < 8; i++) begin
      words[i] = 16'($random(seed));
      m.send_word(words[i], got);
      check(got === 1'b1, "word refused in safeop");
    end
    m.send_word(16'($random(seed)), got);
    check(got === 1'b0, "full buffer took a word");
    check(phys_out === safe_value, "outputs not safe");
    go(slave_comm_pkg::REQ_OP, 3'h7, slave_comm_pkg::CODE_OP, slave_comm_pkg::ERR_NONE);
    check(phys_out === safe_value, "stalled outputs moved");
    @(posedge core_clk);
    phys_ready <= 1'b1;
    idx = 0;
    repeat (30) begin
      @(posedge core_clk);
      #1 if (idx < 8 && phys_out === words[idx]) idx++;
    end
    check(idx == 8, "output words lost or reordered");
    mbx_sweep();
    go(slave_comm_pkg::REQ_SAFEOP, 3'h7, slave_comm_pkg::CODE_SAFEOP, slave_comm_pkg::ERR_NONE);
    @(posedge core_clk) watchdog_enable <= 1'b0;
    m.send_word(words[0], got);
    repeat (3) @(posedge core_clk);
    #1 check(got === 1'b1 && phys_out === words[0], "watchdog off");
    go(slave_comm_pkg::REQ_PREOP, 3'h7, slave_comm_pkg::CODE_PREOP, slave_comm_pkg::ERR_NONE);
    @(posedge core_clk);
    resetn <= 1'b0;
    @(posedge core_clk);
    resetn <= 1'b1;
    cur = slave_comm_pkg::CODE_INIT;
    #1 check(state_code === slave_comm_pkg::CODE_INIT, "mid-run reset");
    tv = {$random(seed), $random(seed)};
    m.load_time(tv);
    #1 check(local_time === tv, "time load");
    repeat (5) @(posedge core_clk);
    #1 check(local_time === tv + 64'(5 * slave_comm_pkg::TIME_STEP), "time step");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
